// file: logic/rsdt_sequencer.sv
// rail sequence delay timer: serial register port, timebase and five delayed outputs
`timescale 1ns/1ps
`include "rsdt_defines.svh"

// Summary of operation
// - The step-down converter b turns on its on-delay (bits 3:0) after the enable pin rises.
// - The step-down converter b turns off its off-delay (bits 7:4) after the enable pin falls.
// - Linear regulator a turns on only after its on-delay in bits 3:0 has elapsed.
// - Linear regulator a turns off only after its off-delay in bits 7:4 has elapsed.
// - Linear regulator b applies its on-delay in bits 3:0 before turning on.
// - Linear regulator b applies its off-delay in bits 7:4 before turning off.
// - General output one rises only after the delay coded in bits 3:0 has passed.
// - General output one falls only after the delay coded in bits 7:4 has passed.
// - General output two rises only after the delay coded in its bits 3:0 has passed.
// - General output two falls only after the delay coded in its bits 7:4 has passed.
// - With the on-range bit clear a turn-on code counts 0.5 ms steps, zero meaning no delay.
// - With the on-range bit set every turn-on code counts 1 ms steps, up to 15 ms.
// - With the off-range bit set every turn-off code counts 1 ms steps, up to 15 ms.
// - A regulator follows the pin delays only when its pin-follow bit is set.
// - A general output follows the pin only when its pin-follow bit is set.
module rsdt_sequencer
  import rsdt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `RSDT_STEP_CYCLES,
  parameter logic [6:0] DEV_ADDR = `RSDT_DEV_ADDR // arbitrary value
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire rsdt_pkg::rsdt_range_t range_i,
  input wire logic [4:0] pin_follow_i,
  input wire logic [4:0] sw_enable_i,
  output logic [4:0] rail_en_o
);
  import rsdt_pkg::*;

  logic en_meta_q;
  logic en_sync_q;
  logic en_prev_q;
  logic pin_rise;
  logic pin_fall;
  logic [15:0] tb_cnt_q;
  logic tick;
  rsdt_delay_t regs_q [`RSDT_NUM_CHAN];
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  rsdt_state_t state_q;
  rsdt_state_t after_q;
  logic [2:0] bit_cnt_q;
  logic full_q;
  logic nack_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic wr_en_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rd_data;
  logic [7:0] rd_idx;

  ////////////////////////////////////////////////////////////////////////
  // enable pin: two-stage synchroniser, then edge detect on the clean copy
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      en_meta_q <= enable_pin_i;
      en_sync_q <= en_meta_q;
      en_prev_q <= en_sync_q;
    end
  end
  assign pin_rise = en_sync_q & ~en_prev_q;
  assign pin_fall = ~en_sync_q & en_prev_q;

  // restarted on every edge so a one-step delay is exactly one step long
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tb_cnt_q <= 16'h0000;
    end else if (pin_rise || pin_fall || tick) begin
      tb_cnt_q <= 16'h0000;
    end else begin
      tb_cnt_q <= tb_cnt_q + 16'h0001;
    end
  end
  assign tick = (tb_cnt_q == 16'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // serial port: sample both lines through two flops, third stage for edges
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_det = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  assign rd_idx = ptr_q - `RSDT_OFF_CONV_B;
  always_comb begin
    if (ptr_q >= `RSDT_OFF_CONV_B && ptr_q <= `RSDT_OFF_OUT_TWO) begin
      rd_data = regs_q[rd_idx[2:0]];
    end else begin
      rd_data = 8'h00;
    end
  end

  // sda is only ever pulled low; released otherwise
  assign sda_o = 1'b0;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= RSDT_IDLE;
      after_q <= RSDT_IDLE;
      bit_cnt_q <= 3'h0;
      full_q <= 1'b0;
      nack_q <= 1'b0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_o <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (start_det) begin
        state_q <= RSDT_ADDR;
        bit_cnt_q <= 3'h0;
        full_q <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        state_q <= RSDT_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_q)
          RSDT_ADDR, RSDT_REG, RSDT_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q[1]};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              full_q <= (bit_cnt_q == 3'h7);
            end else if (scl_fall && full_q) begin
              full_q <= 1'b0;
              state_q <= RSDT_ACK;
              sda_oe_o <= 1'b1;
              if (state_q == RSDT_ADDR) begin
                if (shift_q[7:1] != DEV_ADDR) begin
                  state_q <= RSDT_IDLE;
                  sda_oe_o <= 1'b0;
                end
                after_q <= shift_q[0] ? RSDT_RDATA : RSDT_REG;
              end else if (state_q == RSDT_REG) begin
                ptr_q <= shift_q;
                after_q <= RSDT_WDATA;
              end else begin
                wr_en_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
                after_q <= RSDT_WDATA;
              end
            end
          end
          RSDT_ACK: begin
            if (scl_fall) begin
              state_q <= after_q;
              sda_oe_o <= 1'b0;
              if (after_q == RSDT_RDATA) begin
                tx_q <= {rd_data[6:0], 1'b0};
                sda_oe_o <= ~rd_data[7];
              end
            end
          end
          RSDT_RDATA: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end else if (scl_fall) begin
              if (bit_cnt_q == 3'h0) begin
                state_q <= RSDT_RACK;
                sda_oe_o <= 1'b0;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_o <= ~tx_q[7];
              end
            end
          end
          RSDT_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_q[1];
              if (!sda_q[1]) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end else if (scl_fall) begin
              state_q <= nack_q ? RSDT_IDLE : RSDT_RDATA;
              tx_q <= {rd_data[6:0], 1'b0};
              sda_oe_o <= ~nack_q & ~rd_data[7];
            end
          end
          default: begin
            state_q <= RSDT_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delay registers; writes outside the map are dropped
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < `RSDT_NUM_CHAN; i++) begin
        regs_q[i] <= `RSDT_DELAY_RESET;
      end
    end else if (wr_en_q && wr_addr_q >= `RSDT_OFF_CONV_B
                 && wr_addr_q <= `RSDT_OFF_OUT_TWO) begin
      regs_q[3'(wr_addr_q - `RSDT_OFF_CONV_B)] <= wr_data_q;
    end
  end

  // channel 0 converter b, 1/2 linear regulators a/b, 3/4 general outputs
  for (genvar c = 0; c < `RSDT_NUM_CHAN; c++) begin : g_chan
    rsdt_delay_chan u_chan (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .delay_i(regs_q[c]),
      .range_i(range_i),
      .pin_rise_i(pin_rise),
      .pin_fall_i(pin_fall),
      .tick_i(tick),
      .pin_follow_i(pin_follow_i[c]),
      .sw_enable_i(sw_enable_i[c]),
      .out_o(rail_en_o[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // the counter must step by one between restarts, or the tick spacing drifts
  tick_period_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !tick && !pin_rise && !pin_fall |=> tb_cnt_q == $past(tb_cnt_q) + 16'h0001)
    else $error("timebase skipped a count");
  edge_restart_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_rise || pin_fall |=> tb_cnt_q == 16'h0000)
    else $error("timebase not restarted on enable edge");
  reg_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_en_q && wr_addr_q == `RSDT_OFF_CONV_B |=> regs_q[0] == $past(wr_data_q))
    else $error("delay register write lost");
  write_c: cover property (@(posedge clk_i) disable iff (reset_i)
    wr_en_q && wr_addr_q == `RSDT_OFF_OUT_TWO);
  read_c: cover property (@(posedge clk_i) disable iff (reset_i)
    state_q == RSDT_RACK && scl_fall && !nack_q);

endmodule // rsdt_sequencer

// file: logic/rsdt_defines.svh
// offsets, reset values and timing counts of the rail sequence delay timer
`ifndef RSDT_DEFINES_SVH
`define RSDT_DEFINES_SVH

`define RSDT_OFF_CONV_B 8'h0D
`define RSDT_OFF_LREG_A 8'h0E
`define RSDT_OFF_LREG_B 8'h0F
`define RSDT_OFF_OUT_ONE 8'h10
`define RSDT_OFF_OUT_TWO 8'h11
`define RSDT_NUM_CHAN 5
`define RSDT_DELAY_RESET 8'h00
`define RSDT_CLK_PERIOD_NS 10
`define RSDT_STEP_NS 500000
`define RSDT_STEP_CYCLES (`RSDT_STEP_NS / `RSDT_CLK_PERIOD_NS)
`define RSDT_DEV_ADDR 7'h2A

`endif

// file: logic/rsdt_pkg.sv
// types shared by the rail sequence delay timer
package rsdt_pkg;

  typedef struct packed {
    logic [3:0] off_code;
    logic [3:0] on_code;
  } rsdt_delay_t;

  typedef struct packed {
    logic on_range;
    logic off_range;
  } rsdt_range_t;

  typedef enum logic [3:0] {
    RSDT_IDLE,
    RSDT_ADDR,
    RSDT_REG,
    RSDT_WDATA,
    RSDT_ACK,
    RSDT_RDATA,
    RSDT_RACK
  } rsdt_state_t;

endpackage

// file: logic/rsdt_delay_chan.sv
// one delayed output channel following the enable pin
`timescale 1ns/1ps
module rsdt_delay_chan
  import rsdt_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire rsdt_pkg::rsdt_delay_t delay_i,
  input wire rsdt_pkg::rsdt_range_t range_i,
  input wire logic pin_rise_i,
  input wire logic pin_fall_i,
  input wire logic tick_i,
  input wire logic pin_follow_i,
  input wire logic sw_enable_i,
  output logic out_o
);
  import rsdt_pkg::*;

  logic [4:0] on_target;
  logic [4:0] off_target;
  logic [4:0] cnt_q;
  logic pending_q;
  logic dir_q;
  logic level_q;

  // delays counted in half-step ticks, so a 1 ms step is two ticks
  assign on_target = range_i.on_range ? {delay_i.on_code, 1'b0} : {1'b0, delay_i.on_code};
  assign off_target = range_i.off_range ? {delay_i.off_code, 1'b0} : {1'b0, delay_i.off_code};

  ////////////////////////////////////////////////////////////////////////
  // a new edge always cancels whatever was pending
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 5'h00;
      pending_q <= 1'b0;
      dir_q <= 1'b0;
      level_q <= 1'b0;
    end else if (pin_rise_i) begin
      dir_q <= 1'b1;
      cnt_q <= on_target;
      pending_q <= (on_target != 5'h00);
      if (on_target == 5'h00) begin
        level_q <= 1'b1;
      end
    end else if (pin_fall_i) begin
      dir_q <= 1'b0;
      cnt_q <= off_target;
      pending_q <= (off_target != 5'h00);
      if (off_target == 5'h00) begin
        level_q <= 1'b0;
      end
    end else if (pending_q && tick_i) begin
      if (cnt_q == 5'h01) begin
        level_q <= dir_q;
        pending_q <= 1'b0;
      end
      cnt_q <= cnt_q - 5'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_o <= 1'b0;
    end else begin
      out_o <= pin_follow_i ? (sw_enable_i & level_q) : sw_enable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  zero_on_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_rise_i && on_target == 5'h00 |=> level_q && !pending_q)
    else $error("zero turn-on code did not switch at once");
  range_on_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_rise_i && range_i.on_range && delay_i.on_code == 4'hF |=> cnt_q == 5'h1E)
    else $error("long turn-on range not applied");
  range_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_fall_i && range_i.off_range && delay_i.off_code == 4'h1 |=> cnt_q == 5'h02)
    else $error("long turn-off range not applied");
  restart_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pending_q && pin_fall_i |=> !dir_q && cnt_q == $past(off_target))
    else $error("pending transition not restarted");
  hold_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pending_q && !tick_i && !pin_rise_i && !pin_fall_i |=> $stable(level_q) && $stable(cnt_q))
    else $error("level moved without a tick");
  expire_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pending_q && tick_i && cnt_q == 5'h01 && !pin_rise_i && !pin_fall_i
      |=> level_q == $past(dir_q) ##1 out_o == ($past(pin_follow_i) ?
        ($past(sw_enable_i) && $past(level_q)) : $past(sw_enable_i)))
    else $error("delayed level not applied on expiry");
  sw_only_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !pin_follow_i |=> out_o == $past(sw_enable_i))
    else $error("output ignored its software bit");
  delayed_rise_c: cover property (@(posedge clk_i) disable iff (reset_i)
    pending_q && dir_q && tick_i && cnt_q == 5'h01);
  cancel_c: cover property (@(posedge clk_i) disable iff (reset_i)
    pending_q && dir_q && pin_fall_i);

endmodule // rsdt_delay_chan

// file: bench/rsdt_host_model.sv
// host model: drives the enable pin and the serial register port
`timescale 1ns/1ps
module rsdt_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o,
  output logic enable_pin_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    enable_pin_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // five clocks a phase, above the four the port needs
  task automatic half();
    repeat (5) @(negedge clk_i);
  endtask
  task automatic set_pin(input logic v);
    @(negedge clk_i);
    enable_pin_o = v;
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_pull_o = 1'b1;
    half();
    scl_o = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_pull_o = 1'b0;
    half();
  endtask
  // data never moves in the same step as the clock falls: a fake start could be seen
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_pull_o = (i < 0) ? mack : ~tx[i];
      half();
      scl_o = 1'b1;
      half();
      if (i < 0) ack = ~sda_i;
      else rx[i] = sda_i;
      scl_o = 1'b0;
      half();
    end
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d,
                           output logic ack);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({dev, 1'b0}, 1'b0, rx, a0);
    xfer(off, 1'b0, rx, a1);
    xfer(d, 1'b0, rx, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  // reads from the unmapped offset below the block, then the five registers
  task automatic read_all(output logic [7:0] rd [6], output logic ack);
    logic [7:0] rx;
    logic a0, a1, a2, a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b0, rx, a0);
    xfer(8'h0C, 1'b0, rx, a1);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b0, rx, a2);
    for (int i = 0; i < 6; i++) xfer(8'hFF, 1'(i < 5), rd[i], a);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule // rsdt_host_model

// file: bench/tb_rail_sequence_delay_timer.sv
// self-checking bench for the rail sequence delay timer
`timescale 1ns/1ps
module tb_rail_sequence_delay_timer;
  import rsdt_pkg::*;
  localparam int TICK = 10;
  logic clk_i, reset_i, scl, sda_pull, enable_pin, sda_o, sda_oe_o, ack;
  rsdt_range_t range_i;
  logic [4:0] pin_follow_i, sw_enable_i, rail_en_o, seen, expv;
  wire logic sda_line = ~(sda_pull | sda_oe_o); // pulled up unless someone pulls low
  int n_fail = 0;
  int check_count = 0;
  int first_seen [5];
  logic [31:0] lfsr_q = 32'h0000CCD6;
  logic [7:0] regs [5];
  logic [7:0] rd [6];

  rsdt_sequencer #(.TICK_CYCLES(TICK), .DEV_ADDR(7'h2A)) i_rsdt_sequencer (
    .clk_i(clk_i), .reset_i(reset_i), .enable_pin_i(enable_pin), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .range_i(range_i),
    .pin_follow_i(pin_follow_i), .sw_enable_i(sw_enable_i), .rail_en_o(rail_en_o));
  rsdt_host_model #(.DEV_ADDR(7'h2A)) i_rsdt_host_model (
    .clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull),
    .enable_pin_o(enable_pin));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction
  function automatic int expd(int c, logic lvl);
    int n;
    n = lvl ? int'(regs[c][3:0]) : int'(regs[c][7:4]);
    return n * TICK * (((lvl ? range_i.on_range : range_i.off_range) === 1'b1) ? 2 : 1);
  endfunction
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // sync and output registers add a few clocks on top of the delay itself
  task automatic check_time(input int got, input int exp);
    check_count++;
    if (got < exp + 1 || got > exp + 9) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp + 5);
    end
  endtask
  task automatic run_edge(input logic lvl);
    i_rsdt_host_model.set_pin(lvl);
    for (int c = 0; c < 5; c++) first_seen[c] = -1;
    for (int k = 1; k <= 340; k++) begin
      @(negedge clk_i);
      for (int c = 0; c < 5; c++) if (first_seen[c] < 0 && rail_en_o[c] === lvl) first_seen[c] = k;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    reset_i = 1'b1;
    range_i = '0;
    pin_follow_i = 5'h1F;
    sw_enable_i = 5'h1F;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    i_rsdt_host_model.read_all(rd, ack);
    check_val({7'h00, ack}, 8'h01);
    for (int c = 0; c < 6; c++) check_val(rd[c], 8'h00);
    check_val({7'h00, sda_o}, 8'h00);
    $display("reset values done");
    for (int r = 0; r < 4; r++) begin
      @(negedge clk_i);
      range_i = rsdt_range_t'(r[1:0]);
      for (int c = 0; c < 5; c++) begin
        // channel zero covers both end off codes in both ranges, on code 0 in the short range and 15 in the long
        regs[c] = (c == 0) ? (r[1] ? 8'h0F : 8'hF0) : rnd();
        i_rsdt_host_model.write_reg(7'h2A, 8'h0D + 8'(c), regs[c], ack);
        check_val({7'h00, ack}, 8'h01);
      end
      i_rsdt_host_model.write_reg(7'h2B, 8'h0D, 8'h5A, ack);
      check_val({7'h00, ack}, 8'h00);
      // unmapped offset: acknowledged, then dropped
      i_rsdt_host_model.write_reg(7'h2A, 8'h0C, 8'h77, ack);
      check_val({7'h00, ack}, 8'h01);
      i_rsdt_host_model.read_all(rd, ack);
      check_val(rd[0], 8'h00);
      for (int c = 0; c < 5; c++) check_val(rd[c + 1], regs[c]);
      run_edge(1'b1);
      for (int c = 0; c < 5; c++) check_time(first_seen[c], expd(c, 1'b1));
      run_edge(1'b0);
      for (int c = 0; c < 5; c++) check_time(first_seen[c], expd(c, 1'b0));
      $display("range %0d done", r);
    end
    for (int c = 0; c < 5; c++) i_rsdt_host_model.write_reg(7'h2A, 8'h0D + 8'(c), 8'h1F, ack);
    seen = 5'h00;
    i_rsdt_host_model.set_pin(1'b1);
    repeat (30) begin
      @(negedge clk_i);
      seen = seen | rail_en_o;
    end
    i_rsdt_host_model.set_pin(1'b0);
    repeat (340) begin
      @(negedge clk_i);
      seen = seen | rail_en_o;
    end
    check_val({3'h0, seen}, 8'h00);
    $display("cancel done");
    for (int t = 0; t < 4; t++) begin
      pin_follow_i = 5'(rnd());
      sw_enable_i = 5'(rnd());
      i_rsdt_host_model.set_pin(t[0]);
      repeat (360) @(negedge clk_i);
      expv = t[0] ? sw_enable_i : (sw_enable_i & ~pin_follow_i);
      check_val({3'h0, rail_en_o}, {3'h0, expv});
    end
    $display("pin follow done");
    finish_test();
  end
endmodule // tb_rail_sequence_delay_timer
